// *** rtl/vps_regs.sv ***
`timescale 1ns/1ps
`include "vps_consts.svh"
// Functional notes
// - Speed/duplex field shows negotiation result when enabled
// - Otherwise follows speed-low and duplex bits
// - Bit zero writable heartbeat-test disable
// - Heartbeat disable resets to strap level
// - Reset or power control soft reset restores
// - Basic control reset bit also restores
// - Upper half padding; management sees 16 bits
// - Identity word: chip code and revision
// - Byte-order word returns 87654321h constant
// - Ordering follows bus width and endianness
// - Byte-order word readable while not ready
module vps_regs (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire vps_pkg::vps_addr_t  host_addr,
  input  wire logic                host_rd,
  input  wire logic                host_wr,
  input  wire vps_pkg::vps_word_t  host_wdata,
  output logic                     host_rvalid,
  output vps_pkg::vps_word_t       host_rdata,
  input  wire logic                big_endian,
  input  wire logic                bus_16bit,
  input  wire logic                device_ready,
  input  wire logic [4:0]          mii_reg_index,
  input  wire logic                mii_rd,
  input  wire logic                mii_wr,
  input  wire vps_pkg::vps_half_t  mii_wdata,
  output logic                     mii_rvalid,
  output vps_pkg::vps_half_t       mii_rdata,
  input  wire logic                emu_autoneg_enable,
  input  wire logic                emu_speed_select_low,
  input  wire logic                emu_duplex_select,
  input  wire vps_pkg::vps_speed_t autoneg_result,
  input  wire logic                emu_phy_soft_reset_bit,
  input  wire logic                reset_control_reg_phy_rst,
  input  wire logic                power_mgmt_control_reg_phy_rst,
  input  wire logic                heartbeat_disable_strap,
  output logic                     heartbeat_test_disable
);
  import vps_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic vps_speed_t speed_ind(input logic an,
                                           input vps_speed_t res,
                                           input logic sel_lo,
                                           input logic dup);
    if (an) begin
      speed_ind = res;
    end else begin
      speed_ind = {dup, sel_lo, ~sel_lo};
    end
  endfunction

  function automatic vps_word_t order(input vps_word_t w,
                                      input logic be,
                                      input logic b16);
    if (!be) begin
      order = w;
    end else if (b16) begin
      order = {w[23:16], w[31:24], w[7:0], w[15:8]};
    end else begin
      order = {w[7:0], w[15:8], w[23:16], w[31:24]};
    end
  endfunction

  // ****************************************
  // Heartbeat disable and strap
  // ****************************************
  logic      strap_reg, strap_next;
  logic      hb_reg, hb_next;
  logic      soft_rst;
  vps_half_t special_lo;

  assign soft_rst = reset_control_reg_phy_rst |
                    power_mgmt_control_reg_phy_rst |
                    emu_phy_soft_reset_bit;

  always_comb begin
    strap_next = strap_reg;
    hb_next    = hb_reg;
    if (soft_rst) begin
      hb_next = strap_reg;
    end else if (host_wr && host_addr == `VPS_OFF_PHY_SPECIAL &&
                 device_ready) begin
      hb_next = host_wdata[`VPS_HB_BIT];
    end else if (mii_wr && mii_reg_index == `VPS_MII_IDX_SPECIAL) begin
      hb_next = mii_wdata[`VPS_HB_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      strap_reg <= heartbeat_disable_strap;
      hb_reg    <= heartbeat_disable_strap;
    end else begin
      strap_reg <= strap_next;
      hb_reg    <= hb_next;
    end
  end

  assign heartbeat_test_disable = hb_reg;

  assign special_lo = {11'h000,
                       speed_ind(emu_autoneg_enable, autoneg_result,
                                 emu_speed_select_low,
                                 emu_duplex_select),
                       1'b0, hb_reg};

  // ****************************************
  // Read paths
  // ****************************************
  logic      hrv_next, mrv_next;
  vps_word_t hrd_raw, hrd_next;
  vps_half_t mrd_next;

  always_comb begin
    hrd_raw = 32'h0000_0000;
    case (host_addr)
      `VPS_OFF_BYTE_ORDER: hrd_raw = `VPS_BYTE_ORDER_VAL;
      `VPS_OFF_CHIP_IDENTITY_REVISION: begin
        if (device_ready) begin
          hrd_raw = {`VPS_CHIP_ID_DEF, `VPS_CHIP_REV_DEF};
        end
      end
      `VPS_OFF_PHY_SPECIAL: begin
        if (device_ready) begin
          hrd_raw = {16'h0000, special_lo};
        end
      end
      default: hrd_raw = 32'h0000_0000;
    endcase
    hrv_next = host_rd;
    hrd_next = host_rd ? order(hrd_raw, big_endian, bus_16bit)
                       : 32'h0000_0000;
    mrv_next = mii_rd;
    mrd_next = (mii_rd && mii_reg_index == `VPS_MII_IDX_SPECIAL) ?
               special_lo : 16'h0000;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      host_rvalid <= 1'b0;
      host_rdata  <= 32'h0000_0000;
      mii_rvalid  <= 1'b0;
      mii_rdata   <= 16'h0000;
    end else begin
      host_rvalid <= hrv_next;
      host_rdata  <= hrd_next;
      mii_rvalid  <= mrv_next;
      mii_rdata   <= mrd_next;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_byte_le;
    @(posedge clk) disable iff (!resetn)
    host_rd && host_addr == `VPS_OFF_BYTE_ORDER && !big_endian |=>
      host_rvalid && host_rdata == 32'h87654321;
  endproperty
  a_byte_le: assert property (p_byte_le)
    else $error("byte order word wrong");

  property p_byte_be;
    @(posedge clk) disable iff (!resetn)
    host_rd && host_addr == `VPS_OFF_BYTE_ORDER && big_endian &&
      !bus_16bit |=> host_rdata == 32'h21436587;
  endproperty
  a_byte_be: assert property (p_byte_be)
    else $error("big endian order wrong");

  property p_byte_nr;
    @(posedge clk) disable iff (!resetn)
    host_rd && !device_ready && host_addr == `VPS_OFF_BYTE_ORDER &&
      !big_endian ##1 1 |-> host_rdata != 32'h0000_0000;
  endproperty
  a_byte_nr: assert property (p_byte_nr)
    else $error("byte order word blank while not ready");

  property p_an;
    @(posedge clk) disable iff (!resetn)
    mii_rd && mii_reg_index == 5'h1f && emu_autoneg_enable |=>
      mii_rdata[4:2] == $past(autoneg_result);
  endproperty
  a_an: assert property (p_an)
    else $error("negotiated speed not shown");

  property p_forced;
    @(posedge clk) disable iff (!resetn)
    mii_rd && mii_reg_index == 5'h1f && !emu_autoneg_enable |=>
      mii_rdata[4:2] == {$past(emu_duplex_select),
                         $past(emu_speed_select_low),
                         !$past(emu_speed_select_low)};
  endproperty
  a_forced: assert property (p_forced)
    else $error("forced speed not shown");

  property p_hb_wr;
    @(posedge clk) disable iff (!resetn)
    host_wr && host_addr == `VPS_OFF_PHY_SPECIAL && device_ready &&
      !soft_rst |=> heartbeat_test_disable == $past(host_wdata[0]);
  endproperty
  a_hb_wr: assert property (p_hb_wr)
    else $error("heartbeat bit write lost");

  property p_strap;
    @(posedge clk)
    !resetn |=> heartbeat_test_disable == $past(heartbeat_disable_strap);
  endproperty
  a_strap: assert property (p_strap)
    else $error("strap not loaded");

  property p_soft;
    @(posedge clk) disable iff (!resetn)
    reset_control_reg_phy_rst || power_mgmt_control_reg_phy_rst |=>
      heartbeat_test_disable == $past(strap_reg);
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft reset default missed");

  property p_softbit;
    @(posedge clk) disable iff (!resetn)
    emu_phy_soft_reset_bit |=> heartbeat_test_disable == $past(strap_reg);
  endproperty
  a_softbit: assert property (p_softbit)
    else $error("basic control reset missed");

  property p_pad;
    @(posedge clk) disable iff (!resetn)
    host_rd && host_addr == `VPS_OFF_PHY_SPECIAL && !big_endian |=>
      host_rdata[31:16] == 16'h0000 && host_rdata[15:5] == 11'h000 &&
      host_rdata[1] == 1'b0;
  endproperty
  a_pad: assert property (p_pad)
    else $error("padding or reserved bits set");

  property p_id;
    @(posedge clk) disable iff (!resetn)
    host_rd && host_addr == `VPS_OFF_CHIP_IDENTITY_REVISION && device_ready &&
      !big_endian |=> host_rdata[31:16] == `VPS_CHIP_ID_DEF;
  endproperty
  a_id: assert property (p_id)
    else $error("identity code wrong");

  property p_byte_b16;
    @(posedge clk) disable iff (!resetn)
    host_rd && host_addr == `VPS_OFF_BYTE_ORDER && big_endian &&
      bus_16bit |=> host_rdata == 32'h65872143;
  endproperty
  a_byte_b16: assert property (p_byte_b16)
    else $error("half word byte order wrong");

  // Skip the edge after reset, whose request was never taken
  property p_host_rv;
    @(posedge clk) disable iff (!resetn)
    $past(resetn) |-> host_rvalid == $past(host_rd);
  endproperty
  a_host_rv: assert property (p_host_rv)
    else $error("host read answer not exactly one cycle");

  property p_mii_rv;
    @(posedge clk) disable iff (!resetn)
    $past(resetn) |-> mii_rvalid == $past(mii_rd);
  endproperty
  a_mii_rv: assert property (p_mii_rv)
    else $error("management read answer not exactly one cycle");
endmodule

// *** rtl/vps_consts.svh ***
`ifndef VPS_CONSTS_SVH
`define VPS_CONSTS_SVH

// Host word offsets (byte addresses)
`define VPS_OFF_CHIP_IDENTITY_REVISION      12'h050
`define VPS_OFF_BYTE_ORDER  12'h064
`define VPS_OFF_PHY_SPECIAL 12'h1dc

// Management register index of the special word
`define VPS_MII_IDX_SPECIAL 5'h1f

// Constant pattern and identity (identity value is arbitrary)
`define VPS_BYTE_ORDER_VAL  32'h87654321
`define VPS_CHIP_ID_DEF     16'h5a5a
`define VPS_CHIP_REV_DEF    16'h0001

// Field positions in the special word
`define VPS_SPD_HI          4
`define VPS_SPD_LO          2
`define VPS_HB_BIT          0

`endif

// *** rtl/vps_pkg.sv ***
package vps_pkg;
  typedef logic [31:0] vps_word_t;
  typedef logic [15:0] vps_half_t;
  typedef logic [11:0] vps_addr_t;
  typedef logic [2:0]  vps_speed_t;
endpackage

// *** dv/vps_host.sv ***
`timescale 1ns/1ps
// ****
// Host side of the register bus
// ****
module vps_host (
  input  wire logic               clk,
  output vps_pkg::vps_addr_t      host_addr,
  output logic                    host_rd,
  output logic                    host_wr,
  output vps_pkg::vps_word_t      host_wdata,
  input  wire logic               host_rvalid,
  input  wire vps_pkg::vps_word_t host_rdata
);
  import vps_pkg::*;
  initial begin
    host_addr = 12'h0;
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_wdata = 32'h0;
  end
  // Released lines flip so stale values never look valid
  task automatic wr(input vps_addr_t a, input vps_word_t d);
    @(negedge clk);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge clk);
    host_wr = 1'b0;
    host_addr = ~a;
    host_wdata = ~d;
  endtask
  task automatic rd(input vps_addr_t a, output vps_word_t d,
                    output logic v);
    @(negedge clk);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge clk);
    host_rd = 1'b0;
    host_addr = ~a;
    v = host_rvalid;
    d = host_rdata;
  endtask
endmodule

// *** dv/vps_regs_tb.sv ***
`timescale 1ns/1ps
`include "vps_consts.svh"
`define CHK(n,e,s) begin total_checks++; if ((s) !== (e)) begin \
  err_count++; $display("BAD %s exp %h got %h", n, e, s); end end
// ****
// Bench
// ****
module vps_regs_tb;
  import vps_pkg::*;
  logic       clk, resetn, be, b16, rdy, mr, mw, mv, an, sel, dup;
  logic       srst, rrst, prst, strap, hb, rd, wr, rv;
  logic [4:0] idx;
  vps_half_t  mwd, mdat;
  vps_speed_t ares, spd;
  vps_addr_t  addr;
  vps_word_t  wdat, rdat;
  int         err_count, total_checks, cyc;
  vps_word_t  bo [3] = '{32'h87654321, 32'h21436587, 32'h65872143};
  vps_host host (.clk(clk), .host_addr(addr), .host_rd(rd), .host_wr(wr),
    .host_wdata(wdat), .host_rvalid(rv), .host_rdata(rdat));
  vps_regs dut (.clk(clk), .resetn(resetn), .host_addr(addr),
    .host_rd(rd), .host_wr(wr), .host_wdata(wdat), .host_rvalid(rv),
    .host_rdata(rdat), .big_endian(be), .bus_16bit(b16),
    .device_ready(rdy), .mii_reg_index(idx), .mii_rd(mr), .mii_wr(mw),
    .mii_wdata(mwd), .mii_rvalid(mv), .mii_rdata(mdat),
    .emu_autoneg_enable(an), .emu_speed_select_low(sel),
    .emu_duplex_select(dup), .autoneg_result(ares),
    .emu_phy_soft_reset_bit(srst), .reset_control_reg_phy_rst(rrst),
    .power_mgmt_control_reg_phy_rst(prst),
    .heartbeat_disable_strap(strap), .heartbeat_test_disable(hb));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      results();
    end
  end
  task results;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rchk(input vps_addr_t a, input vps_word_t e);
    vps_word_t d;
    logic      v;
    host.rd(a, d, v);
    `CHK("rvalid", 1'b1, v)
    `CHK("rdata", e, d)
  endtask
  task automatic mii(input logic [4:0] i, input logic w,
                     input vps_half_t e);
    @(negedge clk);
    idx = i;
    mwd = e;
    mw = w;
    mr = ~w;
    @(negedge clk);
    {mw, mr} = 2'b00;
    idx = ~i;
    if (!w) begin
      `CHK("mii_rvalid", 1'b1, mv)
      `CHK("mii_rdata", e, mdat)
    end
  endtask
  initial begin
    {resetn, be, b16, rdy, mr, mw, an, sel, dup} = '0;
    {srst, rrst, prst, idx, mwd, ares} = '0;
    strap = 1'b1;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    // Strap moves later; default must stay latched
    strap = 1'b0;
    @(negedge clk);
    `CHK("hb", 1'b1, hb)
    for (int m = 0; m < 3; m++) begin
      be = (m != 0);
      b16 = (m == 2);
      rchk(`VPS_OFF_BYTE_ORDER, bo[m]);
    end
    be = 1'b0;
    rchk(`VPS_OFF_CHIP_IDENTITY_REVISION, 32'h0);
    host.wr(`VPS_OFF_PHY_SPECIAL, 32'h0);
    `CHK("hb", 1'b1, hb)
    $display("test reset done");
    rdy = 1'b1;
    rchk(`VPS_OFF_CHIP_IDENTITY_REVISION, {`VPS_CHIP_ID_DEF, `VPS_CHIP_REV_DEF});
    rchk(12'h000, 32'h0);
    host.wr(`VPS_OFF_PHY_SPECIAL, 32'hffff_fffe);
    rchk(`VPS_OFF_BYTE_ORDER, `VPS_BYTE_ORDER_VAL);
    `CHK("hb", 1'b0, hb)
    for (int i = 0; i < 8; i++) begin
      {an, dup, sel} = i[2:0];
      ares = ~i[2:0];
      // Pair 01 is 10 Mbps, pair 10 is 100 Mbps
      spd = an ? ares : {dup, sel ? 2'b10 : 2'b01};
      rchk(`VPS_OFF_PHY_SPECIAL, {27'h0, spd, 2'b00});
      mii(5'h1f, 1'b0, {11'h0, spd, 2'b00});
    end
    $display("test speed done");
    for (int k = 0; k < 3; k++) begin
      host.wr(`VPS_OFF_PHY_SPECIAL, 32'h1);
      `CHK("hb", 1'b1, hb)
      host.wr(`VPS_OFF_PHY_SPECIAL, 32'h0);
      {srst, rrst, prst} = 3'b100 >> k;
      @(negedge clk);
      {srst, rrst, prst} = 3'b000;
      `CHK("hb", 1'b1, hb)
    end
    // Soft reset held high outranks a clearing write
    srst = 1'b1;
    host.wr(`VPS_OFF_PHY_SPECIAL, 32'h0);
    `CHK("hb", 1'b1, hb)
    srst = 1'b0;
    mii(5'h1f, 1'b1, 16'h0000);
    `CHK("hb", 1'b0, hb)
    mii(5'h05, 1'b1, 16'h0001);
    mii(5'h05, 1'b0, 16'h0000);
    `CHK("hb", 1'b0, hb)
    $display("test soft reset done");
    results();
  end
endmodule
